//--- shared/psu_sup_pkg.sv
// shared constants and types of the supply supervisor
package psu_sup_pkg;
  // register offsets (byte addresses, byte address = 4 * index)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_MASK      = 8'h08;
  localparam logic [7:0] ADDR_OC_LIMIT  = 8'h0C;
  localparam logic [7:0] ADDR_LL_THRESH = 8'h10;
  localparam logic [7:0] ADDR_LL_HYST   = 8'h14;
  localparam logic [7:0] ADDR_OV_LIMIT  = 8'h18;
  localparam logic [7:0] ADDR_UV_LIMIT  = 8'h1C;
  localparam logic [7:0] ADDR_OC_DEB    = 8'h20;
  localparam logic [7:0] ADDR_COMP_LL   = 8'h24;
  localparam logic [7:0] ADDR_COMP_HL   = 8'h28;
  localparam logic [7:0] ADDR_VNOM      = 8'h2C;
  localparam logic [7:0] ADDR_STATE     = 8'h30;

  // control register fields
  localparam int CTRL_CC_EN    = 0;
  localparam int CTRL_OC_REACT = 1;  // 2 bits
  localparam int CTRL_OV_LATCH = 3;
  localparam int CTRL_UV_LATCH = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // over-current reactions
  localparam logic [1:0] OC_HICCUP   = 2'h0;
  localparam logic [1:0] OC_SHUTDOWN = 2'h1;
  localparam logic [1:0] OC_RECT_OFF = 2'h2;

  // status bits
  localparam int ST_OC       = 0;
  localparam int ST_OV_LOCAL = 1;
  localparam int ST_OV_REM   = 2;
  localparam int ST_UV       = 3;
  localparam int ST_CONT     = 4;
  localparam int ST_LL       = 5;
  localparam int ST_RECT_OFF = 6;
  localparam int ST_IND      = 7;
  localparam int ST_W        = 8;

  // reset values of limits
  localparam logic [11:0] OC_LIMIT_RST  = 12'hFFF;
  localparam logic [11:0] LL_THRESH_RST = 12'h000;
  localparam logic [11:0] LL_HYST_RST   = 12'h010;
  localparam logic [11:0] OV_LIMIT_RST  = 12'hFFF;
  localparam logic [11:0] UV_LIMIT_RST  = 12'h000;
  localparam logic [15:0] OC_DEB_RST    = 16'h000A;
  localparam logic [11:0] VNOM_RST      = 12'h800;

  // continuity: 100 mV at a sense scale given in mV per code
  localparam int CONT_MV        = 100;
  localparam int SENSE_MV_PER_LSB = 10;
  localparam logic [11:0] CONT_CODES = 12'(CONT_MV / SENSE_MV_PER_LSB);

  // fold-back: starts at 90 percent, drops up to 60 percent of nominal
  localparam int CC_START_PCT = 90;
  localparam int CC_DROP_PCT  = 60;

  // timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int RESTART_MS   = 1000;
  localparam int RESTART_CYC  = CLK_HZ / 1000 * RESTART_MS;

  // supervisor states, gray from off through run to restart
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_RUN     = 2'b01,
    ST_RESTART = 2'b11,
    ST_LATCHED = 2'b10
  } sup_state_t;

  // sensed values
  typedef struct packed {
    logic [11:0] current;
    logic [11:0] v_pre;
    logic [11:0] v_post;
    logic [11:0] v_load;
  } sense_t;

  // drive outputs
  typedef struct packed {
    logic primary_en;
    logic rect_en;
    logic soft_start;
  } drive_t;
endpackage

//--- rtl/psu_supervisor.sv
// fault, fold-back and light-load supervisor of a digital supply
`timescale 1ns/1ps

// How it works
// (R1) over-current reacts by one second restart, full shutdown, rectifier cut or report only, as programmed
// (R2) in fold-back, above 90% of limit, target drops linearly up to 60%
// (R3) fold-back acts only when enabled; otherwise normal regulation to limit
// (R4) light-load entry and exit use threshold with hysteresis band
// (R5) light load sets light-load and rectifier-off flags, rectifiers off
// (R6) light load selects the light-load compensation set
// (R7) zero light-load threshold never enters light load
// (R8) inductor front sense input raises a status flag only while in light load
// (R9) three voltage senses; load point over-voltage remote, others local
// (R10) over/under voltage may restart automatically after one second
// (R11) latched faults stay off until supply-on request is toggled
// (R12) difference over 100 mV between adjacent senses flags continuity fault
// (R13) two independent compensation sets, light and heavy load
// (R14) third pole fixed at half switching frequency, not programmable
// (R15) integrating pole follows first zero, not programmed directly
// (R16) over-current must persist for programmed debounce before reacting
// (R17) one over-current reaction turns off only the rectifiers
// (R18) each fault and the light-load mode is captured in a readable sticky status bit
// (R19) restart timer holds drives off, then restarts through soft start
module psu_supervisor #(
  parameter int RESTART_CYCLES = psu_sup_pkg::RESTART_CYC
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // sense inputs
  input  wire psu_sup_pkg::sense_t sense,
  input  wire logic                inductor_front_sense_flag,
  input  wire logic                supply_on_request,
  // drive and loop outputs
  output psu_sup_pkg::drive_t      drive,
  output logic [11:0]              v_target,
  output logic [31:0]              comp_coeffs,
  output logic                     light_load,
  // register port
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  // interrupt
  output logic                     irq
);
  // a restart shorter than two cycles is refused; zero would wrap the timer compare
  if (RESTART_CYCLES < 2) begin : g_restart_chk
    $error("RESTART_CYCLES too small");
  end

  logic [31:0]              ctrl_r;
  logic [11:0]              oc_limit_r;
  logic [11:0]              ll_thresh_r;
  logic [11:0]              ll_hyst_r;
  logic [11:0]              ov_limit_r;
  logic [11:0]              uv_limit_r;
  logic [15:0]              oc_deb_r;
  logic [31:0]              comp_ll_r;
  logic [31:0]              comp_hl_r;
  logic [11:0]              vnom_r;
  logic [psu_sup_pkg::ST_W-1:0] status_r;
  logic [psu_sup_pkg::ST_W-1:0] mask_r;
  logic [psu_sup_pkg::ST_W-1:0] events;
  logic                     ind_r;
  logic                     pson_r;
  logic                     pson_prev_r;
  logic                     ll_r;
  logic                     ll_nxt;
  logic [15:0]              deb_cnt_r;
  logic                     oc_fault;
  logic                     oc_raw;
  logic                     ov_loc;
  logic                     ov_rem;
  logic                     uv;
  logic                     cont;
  logic                     rect_cut_r;
  logic [31:0]              rst_cnt_r;
  logic                     ss_r;
  psu_sup_pkg::sup_state_t  state_r;
  logic                     hiccup_fault;
  logic                     latch_fault;
  logic                     pson_toggle;

  // each pin passes its own three-flop filter
  psu_pin_filter i_ind_filter (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (inductor_front_sense_flag),
    .level   (ind_r)
  );
  psu_pin_filter i_pson_filter (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (supply_on_request),
    .level   (pson_r)
  );

  // comparators
  assign oc_raw = sense.current >= oc_limit_r;
  assign ov_loc = (sense.v_pre > ov_limit_r) ||
                  (sense.v_post > ov_limit_r); // R9
  assign ov_rem = sense.v_load > ov_limit_r; // R9
  assign uv     = (state_r == psu_sup_pkg::ST_RUN) && !ss_r &&
                  (sense.v_load < uv_limit_r);

  function automatic logic [11:0] absdiff(input logic [11:0] a,
                                          input logic [11:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  assign cont = (absdiff(sense.v_pre, sense.v_post) >
                 psu_sup_pkg::CONT_CODES) ||
                (absdiff(sense.v_post, sense.v_load) >
                 psu_sup_pkg::CONT_CODES); // R12

  // over-current debounce
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      deb_cnt_r <= 16'h0000;
    end else if (!oc_raw) begin
      deb_cnt_r <= 16'h0000;
    end else if (deb_cnt_r < oc_deb_r) begin
      deb_cnt_r <= deb_cnt_r + 16'h0001; // R16
    end
  end
  assign oc_fault = oc_raw && (deb_cnt_r >= oc_deb_r); // R16

  // light-load detection with hysteresis; the rectifier drive takes the
  // next value so it never lags the light-load output
  always_comb begin
    ll_nxt = ll_r;
    if (ll_thresh_r == 12'h000) begin
      ll_nxt = 1'b0; // R7
    end else if (!ll_r && sense.current < ll_thresh_r) begin
      ll_nxt = 1'b1; // R4
    end else if (ll_r && {1'b0, sense.current} >=
                 {1'b0, ll_thresh_r} + {1'b0, ll_hyst_r}) begin
      ll_nxt = 1'b0; // R4
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) ll_r <= 1'b0;
    else ll_r <= ll_nxt;
  end
  assign light_load = ll_r;

  // classify faults by programmed reaction
  // reaction code 3 only reports the fault
  always_comb begin
    hiccup_fault = 1'b0;
    latch_fault  = 1'b0;
    if (oc_fault) begin
      if (ctrl_r[psu_sup_pkg::CTRL_OC_REACT +: 2] == psu_sup_pkg::OC_HICCUP)
        hiccup_fault = 1'b1; // R1
      else if (ctrl_r[psu_sup_pkg::CTRL_OC_REACT +: 2] ==
               psu_sup_pkg::OC_SHUTDOWN)
        latch_fault = 1'b1; // R1
    end
    if (ov_loc || ov_rem) begin
      if (ctrl_r[psu_sup_pkg::CTRL_OV_LATCH]) latch_fault = 1'b1;
      else hiccup_fault = 1'b1; // R10
    end
    if (uv) begin
      if (ctrl_r[psu_sup_pkg::CTRL_UV_LATCH]) latch_fault = 1'b1;
      else hiccup_fault = 1'b1; // R10
    end
  end

  // filtered edge: pin bounce cannot fake a toggle
  assign pson_toggle = pson_r && !pson_prev_r;

  // supervisor state, restart timer and soft start marker
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r     <= psu_sup_pkg::ST_OFF;
      rst_cnt_r   <= 32'h0;
      ss_r        <= 1'b0;
      pson_prev_r <= 1'b0;
    end else begin
      pson_prev_r <= pson_r;
      ss_r        <= 1'b0;
      case (state_r)
        psu_sup_pkg::ST_OFF: begin
          if (pson_r) begin
            state_r <= psu_sup_pkg::ST_RUN;
            ss_r    <= 1'b1;
          end
        end
        psu_sup_pkg::ST_RUN: begin
          // a dropped request wins over any fault
          if (!pson_r) begin
            state_r <= psu_sup_pkg::ST_OFF;
          end else if (latch_fault) begin
            state_r <= psu_sup_pkg::ST_LATCHED; // R11
          end else if (hiccup_fault) begin
            state_r   <= psu_sup_pkg::ST_RESTART; // R19
            rst_cnt_r <= 32'h0;
          end
        end
        psu_sup_pkg::ST_RESTART: begin
          if (rst_cnt_r >= 32'(RESTART_CYCLES - 1)) begin
            state_r <= psu_sup_pkg::ST_OFF; // R19
          end else begin
            rst_cnt_r <= rst_cnt_r + 32'h1; // R1 R10
          end
        end
        psu_sup_pkg::ST_LATCHED: begin
          // only a fresh rising edge of the request restarts
          if (pson_toggle) begin
            state_r <= psu_sup_pkg::ST_RUN; // R11
            ss_r    <= 1'b1;
          end
        end
        default: state_r <= psu_sup_pkg::ST_OFF;
      endcase
    end
  end

  // rectifier-only over-current reaction; released when current clears
  // primary keeps switching, so the output stays up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rect_cut_r <= 1'b0;
    end else if (oc_fault && ctrl_r[psu_sup_pkg::CTRL_OC_REACT +: 2] ==
                 psu_sup_pkg::OC_RECT_OFF) begin
      rect_cut_r <= 1'b1; // R17
    end else if (!oc_raw) begin
      rect_cut_r <= 1'b0;
    end
  end

  // drives, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive.primary_en <= state_r == psu_sup_pkg::ST_RUN; // R19
      drive.rect_en    <= (state_r == psu_sup_pkg::ST_RUN) &&
                          !ll_nxt && !rect_cut_r; // R5 R17
      drive.soft_start <= ss_r; // R19
    end
  end

  // fold-back target: linear drop from 90% of limit, clamped at 60%
  // 24 bits hold the widest product with margin
  logic [23:0] knee;
  logic [23:0] over;
  logic [23:0] span;
  logic [23:0] drop;
  always_comb begin
    knee = 24'(oc_limit_r) * 24'(psu_sup_pkg::CC_START_PCT) / 24'd100;
    span = 24'(oc_limit_r) - knee;
    over = ({12'h0, sense.current} > knee) ?
           {12'h0, sense.current} - knee : 24'h0;
    if (over > span) over = span;
    drop = (span == 24'h0) ? 24'h0 :
           24'(vnom_r) * 24'(psu_sup_pkg::CC_DROP_PCT) / 24'd100 *
           over / span; // R2
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      v_target <= psu_sup_pkg::VNOM_RST;
    end else if (ctrl_r[psu_sup_pkg::CTRL_CC_EN]) begin
      v_target <= vnom_r - drop[11:0]; // R2 R3
    end else begin
      v_target <= vnom_r; // R3
    end
  end

  // compensation set select; pole 3 and the integrator are fixed inside the
  // filter, the sets carry only zero and second pole positions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) comp_coeffs <= 32'h0;
    else comp_coeffs <= ll_r ? comp_ll_r : comp_hl_r; // R6 R13 R14 R15
  end

  // sticky status, set wins over clear
  // bits set every cycle while the event holds
  assign events = {ind_r && ll_r, ll_r, ll_r, cont, uv,
                   ov_rem, ov_loc, oc_fault}; // R5 R8 R9 R12 R18
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~((wr && addr == psu_sup_pkg::ADDR_STATUS) ?
                  wdata[psu_sup_pkg::ST_W-1:0] : '0)) | events; // R18
    end
  end
  assign irq = |(status_r & mask_r);

  // register writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r      <= psu_sup_pkg::CTRL_RST;
      mask_r      <= '0;
      oc_limit_r  <= psu_sup_pkg::OC_LIMIT_RST;
      ll_thresh_r <= psu_sup_pkg::LL_THRESH_RST;
      ll_hyst_r   <= psu_sup_pkg::LL_HYST_RST;
      ov_limit_r  <= psu_sup_pkg::OV_LIMIT_RST;
      uv_limit_r  <= psu_sup_pkg::UV_LIMIT_RST;
      oc_deb_r    <= psu_sup_pkg::OC_DEB_RST;
      comp_ll_r   <= 32'h0;
      comp_hl_r   <= 32'h0;
      vnom_r      <= psu_sup_pkg::VNOM_RST;
    end else if (wr) begin
      case (addr)
        psu_sup_pkg::ADDR_CTRL:      ctrl_r      <= {27'h0, wdata[4:0]};
        psu_sup_pkg::ADDR_MASK:      mask_r  <= wdata[psu_sup_pkg::ST_W-1:0];
        psu_sup_pkg::ADDR_OC_LIMIT:  oc_limit_r  <= wdata[11:0];
        psu_sup_pkg::ADDR_LL_THRESH: ll_thresh_r <= wdata[11:0];
        psu_sup_pkg::ADDR_LL_HYST:   ll_hyst_r   <= wdata[11:0];
        psu_sup_pkg::ADDR_OV_LIMIT:  ov_limit_r  <= wdata[11:0];
        psu_sup_pkg::ADDR_UV_LIMIT:  uv_limit_r  <= wdata[11:0];
        psu_sup_pkg::ADDR_OC_DEB:    oc_deb_r    <= wdata[15:0];
        psu_sup_pkg::ADDR_COMP_LL:   comp_ll_r   <= wdata; // R13
        psu_sup_pkg::ADDR_COMP_HL:   comp_hl_r   <= wdata; // R13
        psu_sup_pkg::ADDR_VNOM:      vnom_r      <= wdata[11:0];
        default: ;
      endcase
    end
  end

  // register reads, one cycle later; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        psu_sup_pkg::ADDR_CTRL:      rdata <= ctrl_r;
        psu_sup_pkg::ADDR_STATUS:    rdata <= 32'(status_r);
        psu_sup_pkg::ADDR_MASK:      rdata <= 32'(mask_r);
        psu_sup_pkg::ADDR_OC_LIMIT:  rdata <= 32'(oc_limit_r);
        psu_sup_pkg::ADDR_LL_THRESH: rdata <= 32'(ll_thresh_r);
        psu_sup_pkg::ADDR_LL_HYST:   rdata <= 32'(ll_hyst_r);
        psu_sup_pkg::ADDR_OV_LIMIT:  rdata <= 32'(ov_limit_r);
        psu_sup_pkg::ADDR_UV_LIMIT:  rdata <= 32'(uv_limit_r);
        psu_sup_pkg::ADDR_OC_DEB:    rdata <= 32'(oc_deb_r);
        psu_sup_pkg::ADDR_COMP_LL:   rdata <= comp_ll_r;
        psu_sup_pkg::ADDR_COMP_HL:   rdata <= comp_hl_r;
        psu_sup_pkg::ADDR_VNOM:      rdata <= 32'(vnom_r);
        psu_sup_pkg::ADDR_STATE:     rdata <= {29'h0, ll_r, state_r};
        default:                     rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule

// three-flop filter of an asynchronous pin; a change counts only once
// stages two and three agree, so one metastable sample cannot pass
module psu_pin_filter (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // pin and its filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sync_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_r <= 3'h0;
      level  <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], pin};
      if (sync_r[1] == sync_r[2]) level <= sync_r[2];
    end
  end
endmodule

//--- test/psu_supervisor_properties.sv
// port-level checks of the supply supervisor
`timescale 1ns/1ps
module psu_supervisor_properties #(
  parameter int RESTART_CYCLES = 20
) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // watched ports
  input wire psu_sup_pkg::drive_t drive,
  input wire logic                light_load,
  input wire logic                supply_on_request,
  input wire logic                rd,
  input wire logic [31:0]         rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] off_cnt_r;
  logic        arm_r;

  // request held high across the fall: the drop came from a fault
  sequence s_fault_off;
    $fell(drive.primary_en) ##0
      (supply_on_request && $past(supply_on_request, 6));
  endsequence

  sequence s_soft_pulse;
    drive.soft_start ##1 !drive.soft_start;
  endsequence

  always_ff @(posedge ref_clk) begin
    if (!rst_n || drive.primary_en) begin
      off_cnt_r <= '0;
    end else begin
      off_cnt_r <= off_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arm_r <= 1'b0;
    end else if ($fell(drive.primary_en) && supply_on_request &&
                 $past(supply_on_request, 6)) begin
      arm_r <= 1'b1;
    end else if (drive.primary_en) begin
      arm_r <= 1'b0;
    end
  end

  a_ll_rect_off:
    assert property (light_load |-> !drive.rect_en)
    else $error("rectifier on in light load");
  a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_soft_primary:
    assert property (drive.soft_start |-> drive.primary_en)
    else $error("soft start without primary");
  a_start_soft:
    assert property ($rose(drive.primary_en) |-> s_soft_pulse)
    else $error("run start without one-cycle soft start");
  a_rect_needs_pri:
    assert property (drive.rect_en |-> drive.primary_en)
    else $error("rectifier on with primary off");
  a_restart_hold:
    assert property (s_fault_off |-> !drive.primary_en [*8])
    else $error("drive back too soon after fault");
  a_restart_len:
    assert property ($rose(drive.primary_en) && arm_r |->
                     off_cnt_r >= RESTART_CYCLES)
    else $error("off period after fault too short");
  a_req_before_run:
    assert property ($rose(drive.primary_en) |->
                     $past(supply_on_request, 2))
    else $error("run started without supply-on request");
endmodule

//--- test/psu_stage_model.sv
// power stage stand-in: sense values follow bench commands
`timescale 1ns/1ps
module psu_stage_model (
  // from the supervisor
  input  wire psu_sup_pkg::drive_t drive,
  // bench commands
  input  wire psu_sup_pkg::sense_t cmd,
  input  wire logic                ind_cmd,
  // to the supervisor
  output psu_sup_pkg::sense_t      sense,
  output logic                     inductor_front_sense_flag
);
  // no load current while the primary is not switching
  always_comb begin
    sense = cmd;
    if (!drive.primary_en) begin
      sense.current = 12'h000;
    end
  end
  // front-side ringing only shows once rectifiers are off
  assign inductor_front_sense_flag = ind_cmd & ~drive.rect_en;
endmodule

//--- test/psu_supervisor_test.sv
// self-checking bench of the supply supervisor
`timescale 1ns/1ps
module psu_supervisor_test;
  localparam int RC = 20;
  localparam psu_sup_pkg::sense_t NOM = '{12'h200, 12'h400, 12'h400, 12'h400};
  logic                ref_clk;
  logic                rst_n;
  psu_sup_pkg::sense_t cmd;
  psu_sup_pkg::sense_t sense;
  logic                ind_cmd;
  logic                inductor_front_sense_flag;
  logic                supply_on_request;
  psu_sup_pkg::drive_t drive;
  logic [11:0]         v_target;
  logic [31:0]         comp_coeffs;
  logic                light_load;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic                wr;
  logic                rd;
  logic [31:0]         rdata;
  logic                irq;
  logic [31:0]         v;
  logic [31:0]         cll;
  logic [31:0]         chl;
  logic [11:0]         c;
  logic [7:0]          ra [10];
  logic [31:0]         rv [10];
  int                  mismatches;
  int                  checked;
  int                  n;
  int                  tick;
  int                  t0;

  psu_supervisor #(.RESTART_CYCLES(RC)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sense(sense),
    .inductor_front_sense_flag(inductor_front_sense_flag),
    .supply_on_request(supply_on_request), .drive(drive),
    .v_target(v_target), .comp_coeffs(comp_coeffs),
    .light_load(light_load), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq));
  psu_stage_model i_stage (
    .drive(drive), .cmd(cmd), .ind_cmd(ind_cmd), .sense(sense),
    .inductor_front_sense_flag(inductor_front_sense_flag));

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int tol = 0);
    checked++;
    if ((^g === 1'bx) || g > e + tol || g + tol < e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask

  // bounded wait, n ends as the count of cycles waited
  task automatic wait_pri(logic val);
    n = 0;
    while (drive.primary_en !== val) begin
      @(negedge ref_clk);
      n++;
      if (n > 200) begin
        mismatches++;
        test_done();
      end
    end
  endtask

  // linear drop from the knee down to the full drop at the limit
  function automatic logic [31:0] exp_fold(logic [11:0] cur, logic [11:0] l);
    int knee;
    int vn;
    knee = int'(l) * psu_sup_pkg::CC_START_PCT / 100;
    vn = int'(psu_sup_pkg::VNOM_RST);
    if (int'(cur) <= knee) return 32'(vn);
    return 32'(vn - vn * psu_sup_pkg::CC_DROP_PCT * (int'(cur) - knee) /
               (100 * (int'(l) - knee)));
  endfunction

  always @(posedge ref_clk) tick <= tick + 1;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    ind_cmd = 1'b0;
    supply_on_request = 1'b0;
    cmd = NOM;
    ra = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C,
           8'h3C};
    rv = '{32'h0, 32'h0, 32'hFFF, 32'h0, 32'h10, 32'hFFF, 32'h0, 32'hA,
           32'h800, 32'h0};
    void'($urandom(32'h4e58));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk("reset value", rv[i], v);
    end
    cll = $urandom();
    chl = $urandom();
    wr_reg(psu_sup_pkg::ADDR_COMP_LL, cll);
    wr_reg(psu_sup_pkg::ADDR_COMP_HL, chl);
    wr_reg(psu_sup_pkg::ADDR_OC_LIMIT, 32'h800);
    wr_reg(psu_sup_pkg::ADDR_UV_LIMIT, 32'h100);
    wr_reg(psu_sup_pkg::ADDR_OV_LIMIT, 32'hC00);
    wr_reg(psu_sup_pkg::ADDR_MASK, 32'h1);
    rd_reg(psu_sup_pkg::ADDR_COMP_LL);
    chk("comp light readback", cll, v);
    @(posedge ref_clk) supply_on_request <= 1'b1;
    wait_pri(1);
    chk("soft start", 1, drive.soft_start);
    chk("heavy set", chl, comp_coeffs);
    // light load: zero threshold first, then entry, band, exit
    @(posedge ref_clk) cmd.current <= 12'h001;
    cyc(10);
    chk("zero threshold", 0, light_load);
    chk("rect at zero threshold", 1, drive.rect_en);
    wr_reg(psu_sup_pkg::ADDR_LL_HYST, 32'h40);
    wr_reg(psu_sup_pkg::ADDR_LL_THRESH, 32'h100);
    @(posedge ref_clk) ind_cmd <= 1'b1;
    cyc(8);
    chk("light load", 1, light_load);
    chk("rect off", 0, drive.rect_en);
    chk("light set", cll, comp_coeffs);
    chk("masked irq", 0, irq);
    rd_reg(psu_sup_pkg::ADDR_STATUS);
    chk("light flag", 1, v[psu_sup_pkg::ST_LL]);
    chk("rect flag", 1, v[psu_sup_pkg::ST_RECT_OFF]);
    chk("front flag", 1, v[psu_sup_pkg::ST_IND]);
    @(posedge ref_clk) cmd.current <= 12'h13F;
    cyc(5);
    chk("inside band", 1, light_load);
    @(posedge ref_clk) cmd.current <= 12'h140;
    cyc(5);
    chk("exit", 0, light_load);
    chk("rect back", 1, drive.rect_en);
    chk("heavy back", chl, comp_coeffs);
    @(posedge ref_clk) ind_cmd <= 1'b0;
    wr_reg(psu_sup_pkg::ADDR_LL_THRESH, 32'h0);
    wr_reg(psu_sup_pkg::ADDR_STATUS, 32'hFF);
    rd_reg(psu_sup_pkg::ADDR_STATUS);
    chk("cleared status", 0, v);
    // continuity: v_post moved (both pairs differ), then v_load moved (post-load pair only), just inside and just over
    for (int i = 0; i < 2; i++) begin
      for (int d = 10; d < 12; d++) begin
        @(posedge ref_clk);
        cmd.v_post <= (i == 0) ? 12'(12'h400 + d) : 12'h400;
        cmd.v_load <= (i == 1) ? 12'(12'h400 - d) : 12'h400;
        cyc(3);
        wr_reg(psu_sup_pkg::ADDR_STATUS, 32'hFF);
        rd_reg(psu_sup_pkg::ADDR_STATUS);
        chk("continuity", d > 10, v[psu_sup_pkg::ST_CONT]);
      end
    end
    @(posedge ref_clk) cmd <= NOM;
    // fold-back off, then on with random load at or above the knee
    @(posedge ref_clk) cmd.current <= 12'h7FF;
    cyc(4);
    chk("no fold-back", 32'h800, v_target);
    wr_reg(psu_sup_pkg::ADDR_CTRL, 32'h1);
    repeat (8) begin
      c = 12'(1843 + $urandom_range(204));
      @(posedge ref_clk) cmd.current <= c;
      cyc(4);
      chk("fold-back", exp_fold(c, 12'h800), v_target, 2);
    end
    // short over-current burst, then a held one with rectifier-off
    wr_reg(psu_sup_pkg::ADDR_OC_DEB, 32'h5);
    wr_reg(psu_sup_pkg::ADDR_CTRL, 32'h4);
    @(posedge ref_clk) cmd.current <= 12'h800;
    cyc(3);
    @(posedge ref_clk) cmd.current <= 12'h200;
    rd_reg(psu_sup_pkg::ADDR_STATUS);
    chk("debounced", 0, v[psu_sup_pkg::ST_OC]);
    @(posedge ref_clk) cmd.current <= 12'h800;
    cyc(10);
    chk("oc rect", 0, drive.rect_en);
    chk("oc primary", 1, drive.primary_en);
    chk("oc irq", 1, irq);
    @(posedge ref_clk) cmd.current <= 12'h200;
    cyc(4);
    chk("rect released", 1, drive.rect_en);
    wr_reg(psu_sup_pkg::ADDR_STATUS, 32'hFF);
    cyc(1);
    chk("irq cleared", 0, irq);
    // faults: hiccup oc, shutdown oc, remote ov, local ov, latched uv
    for (int i = 0; i < 5; i++) begin
      wr_reg(psu_sup_pkg::ADDR_CTRL, (i == 1) ? 32'h2 : (i == 4) ? 32'h10 : 0);
      @(posedge ref_clk);
      case (i)
        0, 1: cmd.current <= 12'h800;
        2: cmd.v_load <= 12'hD00;
        3: cmd.v_pre <= 12'hD00;
        default: cmd.v_load <= 12'h080;
      endcase
      wait_pri(0);
      t0 = tick;
      @(posedge ref_clk) cmd <= NOM;
      rd_reg(psu_sup_pkg::ADDR_STATE);
      chk("state", (i == 1 || i == 4) ? 2 : 3, v[1:0]);
      rd_reg(psu_sup_pkg::ADDR_STATUS);
      chk("fault flag", 1, v[(i < 2) ? 0 : (i == 2) ? 2 : (i == 3) ? 1 : 3]);
      chk("remote class", i == 2, v[psu_sup_pkg::ST_OV_REM]);
      if (i == 1 || i == 4) begin
        cyc(3 * RC);
        chk("latched off", 0, drive.primary_en);
        @(posedge ref_clk) supply_on_request <= 1'b0;
        cyc(8);
        @(posedge ref_clk) supply_on_request <= 1'b1;
        wait_pri(1);
      end else begin
        wait_pri(1);
        chk("off time", RC + 1, tick - t0, 1);
      end
      chk("restart soft", 1, drive.soft_start);
      wr_reg(psu_sup_pkg::ADDR_STATUS, 32'hFF);
    end
    test_done();
  end
endmodule

bind psu_supervisor psu_supervisor_properties #(
  .RESTART_CYCLES(RESTART_CYCLES)
) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .drive(drive), .light_load(light_load),
  .supply_on_request(supply_on_request), .rd(rd), .rdata(rdata)
);
